// ---- logic/reset_cause_tracker.sv ----
// reset sequencing and reset cause reporting for a small 8-bit core
// assumes i_rstn is the power-on reset, the clear pin and watchdog
// strobe are synchronous to i_mclk, software uses Avalon-MM
//
// Overview of operation
// - five reset causes: power-on, clear run, clear halt, watchdog run/halt.
// - a wake from halt by clear or watchdog is a full reset.
// - some registers are never reset; unknown after power-on, kept otherwise.
// - work register and page bits take their reset values on every reset kind.
// - status bits 4 and 3 record the reset cause for software.
// - clear pin reset while running leaves both flags unchanged.
// - clear pin wake from halt sets timeout flag, clears powerdown flag.
// - watchdog reset while running clears timeout flag, sets powerdown flag.
// - watchdog wake from halt clears both flags.
// - page bits clear on resets; arithmetic bits kept except at power-on.
// - clear pin is active low; reset holds while the pin is low.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns
module reset_cause_tracker
	import rct_pkg::*;
(
	// clock and power-on reset
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	// reset sources
	input  wire logic        i_master_clear_pin_n,
	input  wire logic        i_watchdog_timer_expired,
	// core side
	output logic             o_core_reset_n,
	output logic             o_halted,
	output logic [7:0]       o_status_word,
	output logic             o_irq,
	// avalon-mm slave
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [3:0]  i_avs_byteenable,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest
);

	seq_state_t     state_reg;
	seq_state_t     state_next;
	logic [2:0]     hold_reg;
	logic [2:0]     hold_next;
	logic [2:0]     page_reg;
	logic [2:0]     page_next;
	logic [2:0]     arith_reg;
	logic [2:0]     arith_next;
	logic [1:0]     flags_reg;
	logic [1:0]     flags_next;
	logic [4:0]     mask_reg;
	logic [7:0]     retain_reg;
	logic [7:0]     work_reg;
	logic [31:0]    rdata_reg;
	logic           rd_ack_reg;
	logic [4:0]     events;
	logic [4:0]     ev_set;
	logic [4:0]     ev_clear;

	// cause decode, the clear pin wins over a watchdog strobe
	logic active;
	logic in_halt;
	logic clear_evt;
	logic watchdog_evt;
	logic any_evt;
	assign active       = (state_reg != ST_RESET);
	assign in_halt      = (state_reg == ST_HALT);
	assign clear_evt    = active & ~i_master_clear_pin_n;
	assign watchdog_evt = active & i_master_clear_pin_n
		& i_watchdog_timer_expired;
	assign any_evt      = clear_evt | watchdog_evt;

	always_comb begin
		ev_set                   = 5'h00;
		ev_set[EV_CLEAR_RUN]     = clear_evt & ~in_halt;
		ev_set[EV_CLEAR_HALT]    = clear_evt & in_halt;
		ev_set[EV_WATCHDOG_RUN]  = watchdog_evt & ~in_halt;
		ev_set[EV_WATCHDOG_HALT] = watchdog_evt & in_halt;
	end

	// bus decode
	logic be0;
	logic wr_status;
	logic wr_events;
	logic wr_mask;
	logic wr_control;
	logic wr_retain;
	logic wr_work;
	logic rd_take;
	assign be0        = i_avs_byteenable[0];
	assign wr_status  = i_avs_write & be0 & (i_avs_address == ADDR_STATUS);
	assign wr_events  = i_avs_write & be0 & (i_avs_address == ADDR_EVENTS);
	assign wr_mask    = i_avs_write & be0 & (i_avs_address == ADDR_MASK);
	assign wr_control = i_avs_write & be0
		& (i_avs_address == ADDR_CONTROL);
	assign wr_retain  = i_avs_write & be0 & (i_avs_address == ADDR_RETAIN);
	assign wr_work    = i_avs_write & be0 & (i_avs_address == ADDR_WORK);
	assign rd_take    = i_avs_read & ~rd_ack_reg;
	assign ev_clear   = wr_events ? i_avs_writedata[4:0] : 5'h00;

	// status word view
	logic [7:0] status_view;
	assign status_view = {page_reg, flags_reg, arith_reg};

	// read selection, unmapped addresses read zero
	logic [7:0] rd_mux;
	assign rd_mux =
		(i_avs_address == ADDR_STATUS)  ? status_view :
		(i_avs_address == ADDR_EVENTS)  ? {3'h0, events} :
		(i_avs_address == ADDR_MASK)    ? {3'h0, mask_reg} :
		(i_avs_address == ADDR_CONTROL) ?
			{6'h00, ~o_core_reset_n, in_halt} :
		(i_avs_address == ADDR_RETAIN)  ? retain_reg :
		(i_avs_address == ADDR_WORK)    ? work_reg : 8'h00;

	// sequencer: any wake from halt goes through reset, never back to run
	always_comb begin
		state_next = state_reg;
		hold_next  = hold_reg;
		case (state_reg)
			ST_RUN: begin
				if (any_evt) begin
					state_next = ST_RESET;
					hold_next  = HOLD_LOAD;
				end else if (wr_control
						& i_avs_writedata[CTRL_HALT_BIT]) begin
					state_next = ST_HALT;
				end
			end
			ST_HALT: begin
				if (any_evt) begin
					state_next = ST_RESET;
					hold_next  = HOLD_LOAD;
				end
			end
			default: begin
				if (!i_master_clear_pin_n) begin
					hold_next = HOLD_LOAD;
				end else if (hold_reg == 3'h0) begin
					state_next = ST_RUN;
				end else begin
					hold_next = hold_reg - 3'h1;
				end
			end
		endcase
	end

	// cause flags, stored active low as in the status word
	always_comb begin
		flags_next = flags_reg;
		if (clear_evt & in_halt) begin
			flags_next = 2'h2;
		end else if (watchdog_evt & ~in_halt) begin
			flags_next = 2'h1;
		end else if (watchdog_evt & in_halt) begin
			flags_next = 2'h0;
		end
	end

	// page bits forced clear while in reset, arithmetic bits kept
	always_comb begin
		page_next  = page_reg;
		arith_next = arith_reg;
		if (any_evt | ~active) begin
			page_next = PAGE_RST;
		end else if (wr_status & (state_reg == ST_RUN)) begin
			page_next  = i_avs_writedata[7:PAGE_LSB];
			arith_next = i_avs_writedata[ARITH_MSB:0];
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ST_RESET;
			hold_reg  <= HOLD_LOAD;
		end else begin
			state_reg <= state_next;
			hold_reg  <= hold_next;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			flags_reg <= FLAGS_POR;
			page_reg  <= PAGE_RST;
			arith_reg <= ARITH_RST;
		end else begin
			flags_reg <= flags_next;
			page_reg  <= page_next;
			arith_reg <= arith_next;
		end
	end

	// scratch kept through every reset, unknown after power-up
	always_ff @(posedge i_mclk) begin
		if (wr_retain) begin
			retain_reg <= i_avs_writedata[7:0];
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			work_reg <= WORK_RST;
		end else if (any_evt | ~active) begin
			work_reg <= WORK_RST;
		end else if (wr_work) begin
			work_reg <= i_avs_writedata[7:0];
		end
	end

	// mask and events survive a core reset so the cause can interrupt
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			mask_reg <= MASK_RST;
		end else if (wr_mask) begin
			mask_reg <= i_avs_writedata[4:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < EV_COUNT; gi++) begin : g_ev
			sticky_event_bit #(
				.RESET_VAL (EVENTS_RST[gi])
			) u_ev (
				.i_mclk  (i_mclk),
				.i_rstn  (i_rstn),
				.i_set   (ev_set[gi]),
				.i_clear (ev_clear[gi]),
				.o_flag  (events[gi])
			);
		end
	endgenerate

	// reads answer one cycle after they are seen
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_ack_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
		end else begin
			rd_ack_reg <= rd_take;
			if (rd_take) begin
				rdata_reg <= {24'h00_0000, rd_mux};
			end
		end
	end

	assign o_avs_waitrequest = rd_take;
	assign o_avs_readdata    = rdata_reg;
	assign o_core_reset_n    = active;
	assign o_halted          = in_halt;
	assign o_status_word     = status_view;
	assign o_irq             = |(events & mask_reg);

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	clear_holds_reset_a: assert property (
		!i_master_clear_pin_n |=> !o_core_reset_n)
		else $error("reset released while clear pin low");

	release_hold_a: assert property (
		$rose(i_master_clear_pin_n) ##0 !o_core_reset_n
		|-> !o_core_reset_n [*5] ##1 o_core_reset_n)
		else $error("reset hold after clear pin wrong");

	wake_resets_a: assert property (
		in_halt && (clear_evt || watchdog_evt)
		|=> !o_core_reset_n && !o_halted)
		else $error("halt wake did not reset");

	clear_run_flags_a: assert property (
		clear_evt && !in_halt
		|=> o_status_word[4:3] == $past(o_status_word[4:3]))
		else $error("clear pin run changed flags");

	clear_halt_flags_a: assert property (
		clear_evt && in_halt |=> o_status_word[TIMEOUT_BIT]
		&& !o_status_word[POWERDOWN_BIT])
		else $error("clear pin wake flags wrong");

	watchdog_run_flags_a: assert property (
		watchdog_evt && !in_halt |=> !o_status_word[TIMEOUT_BIT]
		&& o_status_word[POWERDOWN_BIT])
		else $error("watchdog run flags wrong");

	watchdog_halt_flags_a: assert property (
		watchdog_evt && in_halt |=> o_status_word[4:3] == 2'h0)
		else $error("watchdog wake flags wrong");

	page_arith_a: assert property (
		any_evt |=> o_status_word[7:5] == 3'h0
		&& o_status_word[2:0] == $past(o_status_word[2:0]))
		else $error("page or arithmetic bits wrong on reset");

	cause_logged_a: assert property (
		watchdog_evt && in_halt |=> events[EV_WATCHDOG_HALT])
		else $error("wake cause not logged");

	work_cleared_a: assert property (
		any_evt |=> (work_reg == WORK_RST) [*2])
		else $error("work register not reset");

	halt_tracked_a: assert property (
		state_reg == ST_RUN && !any_evt && wr_control
		&& i_avs_writedata[CTRL_HALT_BIT] |=> o_halted)
		else $error("halt not entered");

	cov_clear_halt: cover property (clear_evt && in_halt);
	cov_watchdog_run: cover property (watchdog_evt && !in_halt);
	cov_irq: cover property ($rose(o_irq));
	cov_read: cover property (rd_take ##1 !o_avs_waitrequest);

endmodule

// ---- common/rct_pkg.sv ----
// constants, register map and state type of the reset cause tracker
// assumes one 20 MHz clock and a byte-addressed Avalon-MM slave port
package rct_pkg;

	// register index of the status word, byte address is four times it
	localparam int unsigned REG_IDX_STATUS = 3;
	localparam logic [5:0]  ADDR_STATUS    = 6'(REG_IDX_STATUS * 4);
	localparam logic [5:0]  ADDR_EVENTS    = 6'h10;
	localparam logic [5:0]  ADDR_MASK      = 6'h14;
	localparam logic [5:0]  ADDR_CONTROL   = 6'h18;
	localparam logic [5:0]  ADDR_RETAIN    = 6'h1C;
	localparam logic [5:0]  ADDR_WORK      = 6'h20;

	// status word fields
	localparam int unsigned PAGE_LSB      = 5;
	localparam int unsigned TIMEOUT_BIT   = 4;
	localparam int unsigned POWERDOWN_BIT = 3;
	localparam int unsigned ARITH_MSB     = 2;

	// control word fields
	localparam int unsigned CTRL_HALT_BIT  = 0;
	localparam int unsigned CTRL_RESET_BIT = 1;

	// event status bits
	localparam int unsigned EV_POR           = 0;
	localparam int unsigned EV_CLEAR_RUN     = 1;
	localparam int unsigned EV_CLEAR_HALT    = 2;
	localparam int unsigned EV_WATCHDOG_RUN  = 3;
	localparam int unsigned EV_WATCHDOG_HALT = 4;
	localparam int unsigned EV_COUNT         = 5;

	// reset values
	localparam logic [2:0] PAGE_RST   = 3'h0;
	localparam logic [2:0] ARITH_RST  = 3'h0;
	localparam logic [1:0] FLAGS_POR  = 2'h3;
	localparam logic [4:0] EVENTS_RST = 5'h01;
	localparam logic [4:0] MASK_RST   = 5'h00;
	localparam logic [7:0] WORK_RST   = 8'h00;

	// timing
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned RESET_HOLD_NS  = 200;
	localparam int unsigned RESET_HOLD_CYC =
		(RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0]  HOLD_LOAD      = 3'(RESET_HOLD_CYC);

	typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_HALT} seq_state_t;

endpackage

// ---- logic/sticky_event_bit.sv ----
// one sticky event flag, set by hardware and cleared by software
// assumes set and clear are single-cycle strobes on the same clock
`timescale 1ns/1ns
module sticky_event_bit #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rstn,
	// control
	input  wire logic i_set,
	input  wire logic i_clear,
	// state
	output logic      o_flag
);

	logic flag_reg;
	logic flag_next;

	// a set in the clearing cycle is kept
	assign flag_next = i_set | (flag_reg & ~i_clear);
	assign o_flag    = flag_reg;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			flag_reg <= RESET_VAL;
		end else begin
			flag_reg <= flag_next;
		end
	end

endmodule

// ---- bench/clear_pin_driver.sv ----
// external reset circuit that pulls the active-low clear pin
// assumes requests are synchronous to i_mclk; pin idles high
`timescale 1ns/1ns
module clear_pin_driver (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	// request from the bench
	input  wire logic       i_pulse_req,
	input  wire logic [3:0] i_low_cycles,
	// pin
	output logic            o_master_clear_pin_n
);
	logic [3:0] low_cnt_reg;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn)
			low_cnt_reg <= 4'h0;
		else if (i_pulse_req)
			low_cnt_reg <= i_low_cycles;
		else if (low_cnt_reg != 4'h0)
			low_cnt_reg <= low_cnt_reg - 4'h1;
	end
	// pin is driven low for the requested count, high otherwise
	assign o_master_clear_pin_n = (low_cnt_reg == 4'h0);
endmodule

// ---- bench/reset_cause_tracker_tb_top.sv ----
// self-checking bench for the reset cause tracker
// assumes the design package and clear_pin_driver are compiled first
`timescale 1ns/1ns
module reset_cause_tracker_tb_top;
	import rct_pkg::*;
	logic        i_mclk = 0;
	logic        i_rstn = 0;
	logic        watchdog_strobe = 0;
	logic        pin_req = 0;
	logic        pin_n;
	logic        core_rst_n;
	logic        halted;
	logic        irq;
	logic        wreq;
	logic [7:0]  status;
	logic [5:0]  addr = 6'h0;
	logic        rd = 0;
	logic        wr = 0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata_bus;
	logic [31:0] rdata;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          cyc = 0;

	always #25 i_mclk = ~i_mclk;

	clear_pin_driver clear_pin_driver_inst (
		.i_mclk               (i_mclk),
		.i_rstn               (i_rstn),
		.i_pulse_req          (pin_req),
		.i_low_cycles         (4'h3),
		.o_master_clear_pin_n (pin_n)
	);

	reset_cause_tracker reset_cause_tracker_inst (
		.i_mclk                   (i_mclk),
		.i_rstn                   (i_rstn),
		.i_master_clear_pin_n     (pin_n),
		.i_watchdog_timer_expired (watchdog_strobe),
		.o_core_reset_n           (core_rst_n),
		.o_halted                 (halted),
		.o_status_word            (status),
		.o_irq                    (irq),
		.i_avs_address            (addr),
		.i_avs_read               (rd),
		.i_avs_write              (wr),
		.i_avs_byteenable         (4'hF),
		.i_avs_writedata          (wdata),
		.o_avs_readdata           (rdata_bus),
		.o_avs_waitrequest        (wreq)
	);

	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			$display("unexpected at %0t: run too long", $time);
			stop_test;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// one bus access; request held until waitrequest is low at an edge
	task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_mclk);
		addr  <= a;
		wr    <= w;
		rd    <= !w;
		wdata <= {24'h0, d};
		@(posedge i_mclk);
		while (wreq !== 1'b0 && n < 20) begin
			n++;
			@(posedge i_mclk);
		end
		rdata = rdata_bus;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n == 20) begin
			error_cnt++;
			$display("unexpected at %0t: no bus answer", $time);
		end
	endtask

	task rd_chk(input logic [5:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h0);
		check(rdata, {24'h0, exp});
	endtask

	task wait_run;
		int n;
		n = 0;
		@(negedge i_mclk);
		while (core_rst_n !== 1'b1 && n < 50) begin
			n++;
			@(negedge i_mclk);
		end
		if (n == 50) begin
			error_cnt++;
			$display("unexpected at %0t: core stayed in reset", $time);
		end
	endtask

	task watchdog_pulse;
		@(posedge i_mclk);
		watchdog_strobe <= 1'b1;
		@(posedge i_mclk);
		watchdog_strobe <= 1'b0;
		@(negedge i_mclk);
		check({31'h0, core_rst_n}, 32'h0);
		wait_run;
	endtask

	task pin_pulse;
		@(posedge i_mclk);
		pin_req <= 1'b1;
		@(posedge i_mclk);
		pin_req <= 1'b0;
		@(negedge i_mclk);
		@(negedge i_mclk);
		check({31'h0, core_rst_n}, 32'h0);
		wait_run;
	endtask

	initial begin
		repeat (4) @(posedge i_mclk);
		i_rstn <= 1'b1;
		bus(1'b0, ADDR_STATUS, 8'h0);
		check(rdata & 32'hF8, 32'h18);
		rd_chk(ADDR_EVENTS, 8'h01);
		wait_run;
		bus(1'b1, ADDR_WORK, 8'hA5);
		bus(1'b1, ADDR_RETAIN, 8'h5A);
		bus(1'b1, ADDR_STATUS, 8'hE7);
		rd_chk(ADDR_STATUS, 8'hFF);
		$display("test power-on done");
		pin_pulse;
		rd_chk(ADDR_STATUS, 8'h1F);
		rd_chk(ADDR_WORK, 8'h00);
		rd_chk(ADDR_RETAIN, 8'h5A);
		$display("test clear run done");
		watchdog_pulse;
		rd_chk(ADDR_STATUS, 8'h0F);
		$display("test watchdog run done");
		bus(1'b1, ADDR_CONTROL, 8'h01);
		rd_chk(ADDR_CONTROL, 8'h01);
		pin_pulse;
		check({31'h0, halted}, 32'h0);
		rd_chk(ADDR_STATUS, 8'h17);
		@(negedge i_mclk);
		check({24'h0, status}, 32'h17);
		$display("test clear wake done");
		bus(1'b1, ADDR_CONTROL, 8'h01);
		@(negedge i_mclk);
		check({31'h0, halted}, 32'h1);
		watchdog_pulse;
		check({31'h0, halted}, 32'h0);
		rd_chk(ADDR_STATUS, 8'h07);
		$display("test watchdog wake done");
		rd_chk(ADDR_EVENTS, 8'h1F);
		bus(1'b1, ADDR_MASK, 8'h04);
		@(negedge i_mclk);
		check({31'h0, irq}, 32'h1);
		bus(1'b1, ADDR_EVENTS, 8'h1F);
		@(negedge i_mclk);
		check({31'h0, irq}, 32'h0);
		rd_chk(ADDR_EVENTS, 8'h00);
		rd_chk(6'h3C, 8'h00);
		$display("test events done");
		// second power-on after all flags were cleared
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		rd_chk(ADDR_CONTROL, 8'h02);
		bus(1'b0, ADDR_STATUS, 8'h0);
		check(rdata & 32'hF8, 32'h18);
		rd_chk(ADDR_EVENTS, 8'h01);
		wait_run;
		check({31'h0, core_rst_n}, 32'h1);
		$display("test second power-on done");
		stop_test;
	end
endmodule
